// >>> common/adc_cfg_pkg.sv
/*
  Constants of the converter output configuration bank.
  Assumes: registers are 11 bits, word-indexed, byte address = 4 * index.
*/
package adc_cfg_pkg;
  localparam int unsigned REG_W      = 11;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned SAMPLE_W   = 14;
  localparam int unsigned CHANNELS   = 4;

  // Register indices
  localparam logic [4:0] IDX_PATTERN = 5'h00;
  localparam logic [4:0] IDX_CLKGAIN = 5'h04;
  localparam logic [4:0] IDX_CUSTLO  = 5'h0B;
  localparam logic [4:0] IDX_FINEHI  = 5'h0C;
  localparam logic [4:0] IDX_IFACE   = 5'h0D;
  localparam logic [4:0] IDX_SWRESET = 5'h1E;

  // Writable bits; the rest read as zero
  localparam logic [10:0] MASK_PATTERN = 11'h2E0;
  localparam logic [10:0] MASK_CLKGAIN = 11'h07C;
  localparam logic [10:0] MASK_CUSTLO  = 11'h7FF;
  localparam logic [10:0] MASK_FINEHI  = 11'h707;
  localparam logic [10:0] MASK_IFACE   = 11'h4F7;
  localparam logic [10:0] RST_VALUE    = 11'h000;

  // Field positions
  localparam int unsigned SWRESET_BIT   = 10;
  localparam int unsigned FMT_BIT       = 9;
  localparam int unsigned MODE_LSB      = 5;
  localparam int unsigned CLKGAIN_LSB   = 2;
  localparam int unsigned FINE_LSB      = 8;
  localparam int unsigned CUSTHI_W      = 3;
  localparam int unsigned IF_TWOWIRE    = 0;
  localparam int unsigned IF_SDR        = 1;
  localparam int unsigned IF_16X        = 2;
  localparam int unsigned IF_RISING     = 4;
  localparam int unsigned IF_COARSE     = 5;
  localparam int unsigned IF_LSBFIRST   = 6;
  localparam int unsigned IF_BITWISE    = 7;
  localparam int unsigned IF_OVERRIDE   = 10;

  // Clock buffer gain steps
  localparam logic [4:0] CLKGAIN_MIN  = 5'h18;
  localparam logic [4:0] CLKGAIN_DEF  = 5'h00;
  localparam logic [4:0] CLKGAIN_2    = 5'h0C;
  localparam logic [4:0] CLKGAIN_3    = 5'h0A;
  localparam logic [4:0] CLKGAIN_4    = 5'h09;
  localparam logic [4:0] CLKGAIN_MAX  = 5'h08;

  // Fixed output words
  localparam logic [13:0] WORD_ONES    = 14'h3FFF;
  localparam logic [13:0] WORD_TOGGLEA = 14'h1555;
  localparam logic [13:0] WORD_TOGGLEB = 14'h2AAA;
  localparam logic [13:0] WORD_DESKEW  = 14'h2AAA;
  localparam logic [13:0] WORD_SYNC    = 14'h3F80;

  typedef enum logic [2:0] {
    TP_NORMAL = 3'h0,
    TP_ZEROS  = 3'h1,
    TP_ONES   = 3'h2,
    TP_TOGGLE = 3'h3,
    TP_UNUSED = 3'h4,
    TP_CUSTOM = 3'h5,
    TP_DESKEW = 3'h6,
    TP_SYNC   = 3'h7
  } test_mode_t;
endpackage : adc_cfg_pkg

// >>> common/reg_access_if.sv
/*
  Register access carrier between the bus slave and the register bank.
  Assumes: one access per pulse, data valid with the pulse.
*/
`timescale 1ns/1ps
interface reg_access_if;
  logic        access;
  logic        write;
  logic [4:0]  index;
  logic [10:0] wdata;
  logic [10:0] rdata;
  modport bus  (output access, output write, output index, output wdata, input rdata);
  modport bank (input access, input write, input index, input wdata, output rdata);
endinterface : reg_access_if

// >>> hw/ahb_reg_slave.sv
/*
  AHB-Lite slave: single word transfers, one wait state each.
  Assumes: the only slave on the bus, so hreadyout is hready.
*/
`timescale 1ns/1ps
module ahb_reg_slave
  import adc_cfg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  reg_access_if.bus        acc
);
  logic       pend;
  logic       pendWrite;
  logic [4:0] pendIndex;
  // Only word-sized transfers reach the registers
  wire        start    = hsel & hready & htrans[1] & (hsize == 3'h2);
  // Addresses above the 32-word window alias nothing
  wire        inWindow = (haddr[31:7] == 25'h0000000);

  assign acc.access = pend;
  assign acc.write  = pendWrite;
  assign acc.index  = pendIndex;
  assign acc.wdata  = hwdata[REG_W-1:0];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend      <= 1'b0;
      pendWrite <= 1'b0;
      pendIndex <= 5'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else if (start) begin
      // Wait state keeps hrdata a flop output
      pend      <= 1'b1;
      pendWrite <= hwrite & inWindow;
      pendIndex <= inWindow ? haddr[6:2] : 5'h1F;
      hreadyout <= 1'b0;
    end else if (pend) begin
      pend      <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= {21'h000000, acc.rdata};
    end
  end

  chk_one_wait_state: assert property (@(posedge clk_sys) disable iff (rst)
    start |=> !hreadyout ##1 hreadyout)
    else $error("Transfer did not complete after one wait state");
endmodule : ahb_reg_slave

// >>> hw/pattern_source.sv
/*
  Selects each channel's output word: conversion or test pattern.
  Assumes: sampleIn is offset binary straight from the converter core.
*/
`timescale 1ns/1ps
module pattern_source
  import adc_cfg_pkg::*;
#(
  parameter int unsigned CHANNELS = 4,
  parameter int unsigned WIDTH    = 14
)(
  input  wire logic [2:0]                   mode,
  input  wire logic                         binaryFmt,
  input  wire logic                         togglePhase,
  input  wire logic [WIDTH-1:0]             custom,
  input  wire logic [CHANNELS-1:0][WIDTH-1:0] sampleIn,
  output logic      [CHANNELS-1:0][WIDTH-1:0] word
);
  function automatic logic [WIDTH-1:0] pick(input logic [WIDTH-1:0] s);
    logic [WIDTH-1:0] conv;
    // Two's complement is offset binary with the sign flipped
    conv = binaryFmt ? s : {~s[WIDTH-1], s[WIDTH-2:0]}; // RULE6
    unique case (test_mode_t'(mode)) // RULE3
      TP_NORMAL: pick = conv;
      TP_ZEROS:  pick = '0;
      TP_ONES:   pick = WORD_ONES[WIDTH-1:0];
      TP_TOGGLE: pick = togglePhase ? WORD_TOGGLEB[WIDTH-1:0] : WORD_TOGGLEA[WIDTH-1:0];
      TP_CUSTOM: pick = custom; // RULE4
      TP_DESKEW: pick = WORD_DESKEW[WIDTH-1:0];
      TP_SYNC:   pick = WORD_SYNC[WIDTH-1:0];
      // Unused code falls back to conversion data
      default:   pick = conv;
    endcase
  endfunction : pick

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      word[c] = pick(sampleIn[c]);
    end
  end
endmodule : pattern_source

// >>> hw/adc_output_config_registers.sv
/*
  Output configuration register bank of a quad 14-bit converter, with
  test pattern selection and frame-aligned application of settings.
  Assumes: AHB-Lite master, frameTick one cycle per output frame,
  parallel control pins synchronous to clk_sys.
*/
// Behaviour
// RULE1: Clock gain bits 6..2 select six steps; 11000 min, 00000 default, 01000 max.
// RULE2: Middle gain steps are 01100, 01010, 01001; other codes are undefined.
// RULE3: Pattern bits 7..5 pick normal, zeros, ones, toggle, deskew or sync output.
// RULE4: Pattern code 101 sends the custom pattern on every channel.
// RULE5: Custom low holds pattern bits 10..0; fine gain register holds top three.
// RULE6: Pattern register bit 9 selects two's complement or straight binary.
// RULE7: Fine gain bits 10..8 give 0 to 6 dB in 1 dB steps.
// RULE8: Interface bit 0 picks 1- or 2-wire; bit 1 picks DDR or SDR.
// RULE9: Interface bit 2 picks 14 or 16 bits per serialized sample.
// RULE10: In SDR, bit 4 picks falling or rising capture edge for the receiver.
// RULE11: Interface bit 5 enables 3.5 dB coarse gain.
// RULE12: Interface bit 6 picks MSB first or LSB first word order.
// RULE13: In 2-wire mode bit 7 picks byte-wise or bit-wise lane split.
// RULE14: Parallel pins govern interface functions while override is clear.
// RULE15: Override bit 10 set makes interface register settings win over pins.
// RULE16: Host writes zero into every unused register bit.
// RULE17: Writing the software reset bit restores defaults; the bit self-clears.
// RULE18: Settings apply from the next frame after the write, no power cycle.
`timescale 1ns/1ps
module adc_output_config_registers
  import adc_cfg_pkg::*;
#(
  parameter int unsigned CHANNELS = adc_cfg_pkg::CHANNELS,
  parameter int unsigned WIDTH    = adc_cfg_pkg::SAMPLE_W
)(
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic      [31:0]                    hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  input  wire logic                           pinTwoWire,
  input  wire logic                           pinSdrClk,
  input  wire logic                           pinSerial16x,
  input  wire logic                           pinCaptureRising,
  input  wire logic                           pinCoarseGain,
  input  wire logic                           pinLsbFirst,
  input  wire logic                           pinBitWise,
  input  wire logic                           frameTick,
  input  wire logic [CHANNELS-1:0][WIDTH-1:0] sampleIn,
  output logic      [CHANNELS-1:0][WIDTH-1:0] chanWord,
  output logic      [4:0]                     clkBufGain,
  output logic      [2:0]                     fineGain,
  output logic                                coarseGainEn,
  output logic                                lanesTwoWire,
  output logic                                bitClkSdr,
  output logic                                serial16x,
  output logic                                captureRising,
  output logic                                lsbFirst,
  output logic                                bitWise
);
  import adc_cfg_pkg::*;

  reg_access_if acc ();

  ahb_reg_slave bus (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .acc       (acc.bus)
  );

  logic [10:0] patternReg;
  logic [10:0] clkGainReg;
  logic [10:0] custLowReg;
  logic [10:0] fineHiReg;
  logic [10:0] ifaceReg;
  logic        togglePhase;

  wire wrHit   = acc.access & acc.write;
  wire swReset = wrHit & (acc.index == IDX_SWRESET) & acc.wdata[SWRESET_BIT];
  wire wrPat   = wrHit & (acc.index == IDX_PATTERN);
  wire wrClk   = wrHit & (acc.index == IDX_CLKGAIN);
  wire wrCust  = wrHit & (acc.index == IDX_CUSTLO);
  wire wrFine  = wrHit & (acc.index == IDX_FINEHI);
  wire wrIf    = wrHit & (acc.index == IDX_IFACE);

  // Reserved bits are not stored, so they read as zero whatever is written
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      patternReg <= RST_VALUE;
      clkGainReg <= RST_VALUE;
      custLowReg <= RST_VALUE;
      fineHiReg  <= RST_VALUE;
      ifaceReg   <= RST_VALUE;
    end else if (swReset) begin
      // Defaults restored; the reset bit itself is never stored
      patternReg <= RST_VALUE; // RULE17
      clkGainReg <= RST_VALUE;
      custLowReg <= RST_VALUE;
      fineHiReg  <= RST_VALUE;
      ifaceReg   <= RST_VALUE;
    end else begin
      if (wrPat)  patternReg <= acc.wdata & MASK_PATTERN;
      if (wrClk)  clkGainReg <= acc.wdata & MASK_CLKGAIN; // RULE1 RULE2
      if (wrCust) custLowReg <= acc.wdata & MASK_CUSTLO; // RULE5
      if (wrFine) fineHiReg  <= acc.wdata & MASK_FINEHI; // RULE5
      if (wrIf)   ifaceReg   <= acc.wdata & MASK_IFACE;
    end
  end

  // Read mux; unmapped indices and the reset register read zero
  assign acc.rdata = (acc.index == IDX_PATTERN) ? patternReg :
                     (acc.index == IDX_CLKGAIN) ? clkGainReg :
                     (acc.index == IDX_CUSTLO)  ? custLowReg :
                     (acc.index == IDX_FINEHI)  ? fineHiReg  :
                     (acc.index == IDX_IFACE)   ? ifaceReg   : 11'h000;

  // Field views
  wire [2:0]  modeField = patternReg[MODE_LSB +: 3];
  wire        fmtField  = patternReg[FMT_BIT];
  wire [4:0]  clkField  = clkGainReg[CLKGAIN_LSB +: 5];
  wire [2:0]  fineField = fineHiReg[FINE_LSB +: 3];
  wire [13:0] customPat = {fineHiReg[CUSTHI_W-1:0], custLowReg};
  wire        useReg    = ifaceReg[IF_OVERRIDE];

  // Pins govern unless override is set
  wire effTwo    = useReg ? ifaceReg[IF_TWOWIRE]  : pinTwoWire; // RULE14 RULE15
  wire effSdr    = useReg ? ifaceReg[IF_SDR]      : pinSdrClk; // RULE14 RULE15
  wire eff16x    = useReg ? ifaceReg[IF_16X]      : pinSerial16x; // RULE14 RULE15
  wire effRise   = useReg ? ifaceReg[IF_RISING]   : pinCaptureRising; // RULE14 RULE15
  wire effCoarse = useReg ? ifaceReg[IF_COARSE]   : pinCoarseGain; // RULE14 RULE15
  wire effLsb    = useReg ? ifaceReg[IF_LSBFIRST] : pinLsbFirst; // RULE14 RULE15
  wire effBit    = useReg ? ifaceReg[IF_BITWISE]  : pinBitWise; // RULE14 RULE15

  // SDR, capture edge and lane split only mean something in 2-wire
  wire next_sdr     = effTwo & effSdr; // RULE8
  wire next_rising  = next_sdr & effRise; // RULE10
  wire next_bitWise = effTwo & effBit; // RULE13

  logic [CHANNELS-1:0][WIDTH-1:0] next_word;

  pattern_source #(
    .CHANNELS (CHANNELS),
    .WIDTH    (WIDTH)
  ) patterns (
    .mode        (modeField),
    .binaryFmt   (fmtField),
    .togglePhase (togglePhase),
    .custom      (customPat[WIDTH-1:0]),
    .sampleIn    (sampleIn),
    .word        (next_word)
  );

  // Frame-aligned update keeps a word from mixing old and new settings
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chanWord      <= '0;
      clkBufGain    <= CLKGAIN_DEF;
      fineGain      <= 3'h0;
      coarseGainEn  <= 1'b0;
      lanesTwoWire  <= 1'b0;
      bitClkSdr     <= 1'b0;
      serial16x     <= 1'b0;
      captureRising <= 1'b0;
      lsbFirst      <= 1'b0;
      bitWise       <= 1'b0;
      togglePhase   <= 1'b0;
    end else if (frameTick) begin // RULE18
      chanWord      <= next_word; // RULE3 RULE4 RULE6
      clkBufGain    <= clkField; // RULE1
      fineGain      <= fineField; // RULE7
      coarseGainEn  <= effCoarse; // RULE11
      lanesTwoWire  <= effTwo; // RULE8
      bitClkSdr     <= next_sdr; // RULE8
      serial16x     <= eff16x; // RULE9
      captureRising <= next_rising; // RULE10
      lsbFirst      <= effLsb; // RULE12
      bitWise       <= next_bitWise; // RULE13
      togglePhase   <= ~togglePhase;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_gain_applied: assert property (frameTick |=> clkBufGain == $past(clkField)) // RULE1
    else $error("Clock buffer gain not applied at frame");
  chk_gain_default: assert property (swReset ##1 frameTick |=> clkBufGain == CLKGAIN_DEF) // RULE17
    else $error("Clock buffer gain not default after soft reset");
  chk_zero_pattern: assert property (frameTick && modeField == TP_ZEROS |=> chanWord == '0) // RULE3
    else $error("Zero pattern not output");
  chk_custom_pattern: assert property (frameTick && modeField == TP_CUSTOM
    |=> chanWord[0] == $past(customPat[WIDTH-1:0]) && chanWord[CHANNELS-1] == chanWord[0]) // RULE4
    else $error("Custom pattern not on every channel");
  chk_custom_split: assert property (wrFine && !swReset ##1 frameTick && modeField == TP_CUSTOM
    |=> chanWord[0][WIDTH-1 -: 3] == $past(acc.wdata[2:0], 2)) // RULE5
    else $error("Custom pattern upper bits misplaced");
  chk_data_format: assert property (frameTick && modeField == TP_NORMAL && fmtField
    |=> chanWord[0] == $past(sampleIn[0])) // RULE6
    else $error("Straight binary word altered");
  chk_fine_gain: assert property (frameTick |=> fineGain == $past(fineHiReg[10:8])) // RULE7
    else $error("Fine gain not applied");
  chk_sdr_needs_two: assert property (bitClkSdr || bitWise |-> lanesTwoWire) // RULE8
    else $error("SDR clock outside 2-wire mode");
  chk_frame_hold: assert property (!frameTick |=> $stable(serial16x) && $stable(chanWord)) // RULE9
    else $error("Settings changed mid frame");
  chk_capture_edge: assert property (captureRising |-> bitClkSdr) // RULE10
    else $error("Capture edge set without SDR clock");
  chk_coarse_pin: assert property (frameTick && !useReg |=> coarseGainEn == $past(pinCoarseGain)) // RULE11
    else $error("Coarse gain does not follow pin");
  chk_order_reg: assert property (frameTick && useReg |=> lsbFirst == $past(ifaceReg[6])) // RULE12
    else $error("Bit order does not follow register");
  chk_split_pin: assert property (frameTick && !useReg && pinTwoWire
    |=> bitWise == $past(pinBitWise)) // RULE13
    else $error("Lane split does not follow pin");
  chk_pin_control: assert property (frameTick && !useReg |=> lsbFirst == $past(pinLsbFirst)) // RULE14
    else $error("Pins not in control with override clear");
  chk_override_wins: assert property (frameTick && useReg
    |=> serial16x == $past(ifaceReg[IF_16X]) && lanesTwoWire == $past(ifaceReg[0])) // RULE15
    else $error("Register did not override pins");
  chk_soft_reset: assert property (swReset |=> patternReg == RST_VALUE && ifaceReg == RST_VALUE
    && fineHiReg == RST_VALUE) // RULE17
    else $error("Soft reset did not restore defaults");
  chk_reset_reads_zero: assert property (acc.access && !acc.write && acc.index == IDX_SWRESET
    |=> hrdata == 32'h00000000) // RULE17
    else $error("Soft reset bit did not self-clear");
  chk_next_frame: assert property (wrIf && !swReset ##1 frameTick && useReg
    |=> lsbFirst == $past(acc.wdata[IF_LSBFIRST], 2)) // RULE18
    else $error("Setting not applied at next frame");

  cov_custom_mode: cover property (wrPat ##[1:40] frameTick && modeField == TP_CUSTOM);
  cov_override_on: cover property (wrIf && acc.wdata[IF_OVERRIDE] ##[1:40] frameTick);
  cov_soft_reset:  cover property (swReset ##[1:40] frameTick);
  cov_two_wire_sdr: cover property (bitClkSdr && captureRising && bitWise);
endmodule : adc_output_config_registers

// >>> testbench/ahb_host_model.sv
/*
  Host model: AHB-Lite master issuing single word transfers.
  Assumes: hready is the one slave's hreadyout.
*/
`timescale 1ns/1ps
module ahb_host_model (
  input  wire logic        clk_sys,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  import adc_cfg_pkg::*;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  function automatic logic [10:0] used(input logic [31:0] a);
    case (a[6:2])
      IDX_PATTERN: return MASK_PATTERN;
      IDX_CLKGAIN: return MASK_CLKGAIN;
      IDX_FINEHI:  return MASK_FINEHI;
      IDX_IFACE:   return MASK_IFACE;
      IDX_SWRESET: return 11'h400;
      default:     return 11'h7FF;
    endcase
  endfunction : used
  // Released data lines show the inverse, never a stale copy
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? {21'h0, d[10:0] & used(a)} : ~hwdata;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata;
    hsel <= 1'b0;
  endtask : xfer
endmodule : ahb_host_model

// >>> testbench/adc_output_config_registers_tb.sv
/*
  Bench of the output configuration bank: each scenario drives the bus (t_iface also the pins), then judges.
  Assumes: one wait state per transfer, outputs update one cycle after frameTick.
*/
`timescale 1ns/1ps
module adc_output_config_registers_tb;
  import adc_cfg_pkg::*;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  logic             frameTick = 1'b0;
  logic [6:0]       pins = 7'h00;
  logic [3:0][13:0] sampleIn = {14'h0F03, 14'h2A02, 14'h1C01, 14'h3400};
  wire  [3:0][13:0] chanWord;
  wire  [4:0]       clkBufGain;
  wire  [2:0]       fineGain;
  wire  [6:0]       cfg;
  wire              hsel, hwrite, hready, hresp;
  wire  [1:0]       htrans;
  wire  [2:0]       hsize;
  wire  [31:0]      haddr, hwdata, hrdata;
  logic [31:0]      q;
  logic [4:0]       regIdx [5] = '{IDX_PATTERN, IDX_CLKGAIN, IDX_CUSTLO, IDX_FINEHI, IDX_IFACE};
  int               bad_count = 0;
  int               comparisons = 0;
  int               cycles = 0;
  always #2 clk_sys = ~clk_sys;
  ahb_host_model ahb_host_model_i (.clk_sys(clk_sys), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  adc_output_config_registers adc_output_config_registers_i (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pinTwoWire(pins[0]), .pinSdrClk(pins[1]),
    .pinSerial16x(pins[2]), .pinCaptureRising(pins[3]), .pinCoarseGain(pins[4]), .pinLsbFirst(pins[5]),
    .pinBitWise(pins[6]), .frameTick(frameTick), .sampleIn(sampleIn), .chanWord(chanWord),
    .clkBufGain(clkBufGain), .fineGain(fineGain), .coarseGainEn(cfg[4]), .lanesTwoWire(cfg[0]),
    .bitClkSdr(cfg[1]), .serial16x(cfg[2]), .captureRising(cfg[3]), .lsbFirst(cfg[5]), .bitWise(cfg[6]));
  task automatic check_read(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : check_read
  task automatic check_port(input string n, input logic [55:0] e, input logic [55:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : check_port
  task automatic print_verdict;
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  function automatic logic [31:0] ba(input logic [4:0] i);
    return {25'h0, i, 2'b00};
  endfunction : ba
  // Modes that do not apply read as zero
  function automatic logic [6:0] gated(input logic [6:0] p);
    return {p[6] & p[0], p[5], p[4], p[3] & p[1] & p[0], p[2], p[1] & p[0], p[0]};
  endfunction : gated
  function automatic logic [55:0] normal(input logic straight);
    return straight ? sampleIn : sampleIn ^ {4{14'h2000}};
  endfunction : normal
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb_host_model_i.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd_check(input string n, input logic [31:0] a, input logic [31:0] e);
    ahb_host_model_i.xfer(1'b0, a, 32'h0, q);
    check_read(n, e, q);
  endtask : rd_check
  task automatic frame;
    @(posedge clk_sys);
    frameTick <= 1'b1;
    @(posedge clk_sys);
    frameTick <= 1'b0;
    #1;
  endtask : frame
  task automatic t_reset;
    check_port("chanWord", 56'h0, chanWord);
    check_port("clkBufGain", 56'(CLKGAIN_DEF), 56'(clkBufGain));
    check_port("cfg", 56'h0, 56'(cfg));
    foreach (regIdx[i]) rd_check("reg", ba(regIdx[i]), 32'h0);
  endtask : t_reset
  task automatic t_clkgain;
    logic [4:0] c [6] = '{CLKGAIN_MIN, CLKGAIN_DEF, CLKGAIN_2, CLKGAIN_3, CLKGAIN_4, CLKGAIN_MAX};
    foreach (c[i]) begin
      wr(ba(IDX_CLKGAIN), 32'(c[i]) << 2);
      rd_check("clkgain", ba(IDX_CLKGAIN), 32'(c[i]) << 2);
      frame();
      check_port("clkBufGain", 56'(c[i]), 56'(clkBufGain));
    end
  endtask : t_clkgain
  task automatic t_patterns;
    logic [10:0] mv [4] = '{11'h020, 11'h040, 11'h0C0, 11'h0E0};
    logic [13:0] mw [4] = '{14'h0000, WORD_ONES, WORD_DESKEW, WORD_SYNC};
    logic [55:0] w1;
    foreach (mv[i]) begin
      wr(ba(IDX_PATTERN), 32'(mv[i]));
      if (i == 0) check_port("held", normal(1'b0), chanWord);
      frame();
      check_port("pattern", {4{mw[i]}}, chanWord);
    end
    wr(ba(IDX_PATTERN), 32'h060);
    frame();
    w1 = chanWord;
    frame();
    check_port("toggle", {4{WORD_ONES}}, w1 ^ chanWord);
    wr(ba(IDX_PATTERN), 32'h200);
    frame();
    check_port("straight", normal(1'b1), chanWord);
    wr(ba(IDX_PATTERN), 32'h080);
    frame();
    check_port("unused", normal(1'b0), chanWord);
  endtask : t_patterns
  task automatic t_custom;
    wr(ba(IDX_PATTERN), 32'h0A0);
    // Frames back to back, so a write meets the very next frame
    frameTick <= 1'b1;
    wr(ba(IDX_CUSTLO), 32'h5A3);
    wr(ba(IDX_FINEHI), 32'h605);
    rd_check("fine", ba(IDX_FINEHI), 32'h605);
    frame();
    check_port("custom", {4{14'h2DA3}}, chanWord);
    check_port("fineGain", 56'h6, 56'(fineGain));
  endtask : t_custom
  task automatic t_iface;
    logic [10:0] iv [5] = '{11'h000, 11'h404, 11'h4F7, 11'h4F6, 11'h0F6};
    logic [6:0]  pv [5] = '{7'h7F, 7'h7F, 7'h00, 7'h00, 7'h03};
    logic [6:0]  e;
    foreach (iv[i]) begin
      @(posedge clk_sys);
      frameTick <= 1'b1;
      wr(ba(IDX_IFACE), 32'(iv[i]));
      @(posedge clk_sys);
      pins <= pv[i];
      frame();
      e = gated(iv[i][10] ? {iv[i][7:4], iv[i][2:0]} : pv[i]);
      check_port("iface", 56'(e), 56'(cfg));
    end
  endtask : t_iface
  task automatic t_swreset;
    @(posedge clk_sys);
    frameTick <= 1'b1;
    wr(ba(IDX_SWRESET), 32'h400);
    rd_check("swreset", ba(IDX_SWRESET), 32'h0);
    foreach (regIdx[i]) rd_check("reg", ba(regIdx[i]), 32'h0);
    frame();
    check_port("chanWord", normal(1'b0), chanWord);
    check_port("cfg", 56'(gated(7'h03)), 56'(cfg));
  endtask : t_swreset
  task automatic t_unmapped;
    wr(32'h80, 32'h7FF);
    rd_check("unmapped", 32'h80, 32'h0);
    rd_check("dropped", ba(IDX_PATTERN), 32'h0);
    rd_check("gap", 32'h08, 32'h0);
    check_port("hresp", 56'h0, 56'(hresp));
  endtask : t_unmapped
  // Ceiling far above the few hundred cycles the scenarios need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    t_reset();
    t_clkgain();
    t_patterns();
    t_custom();
    t_iface();
    t_swreset();
    t_unmapped();
    print_verdict();
  end
endmodule : adc_output_config_registers_tb
